// file: hdl/video_window_defines.vh
/*
 Holds register offsets, field widths and reset values of the window geometry bank.
 Assumes it is included by bare name from the design files.
*/
`ifndef VIDEO_WINDOW_DEFINES_VH
`define VIDEO_WINDOW_DEFINES_VH

// ==========================================================
// Register offsets
`define ADDR_INPUT_LINE_COUNT   12'h121
`define ADDR_OUTPUT_LINE_COUNT  12'h122
`define ADDR_HORIZONTAL_START   12'h123
`define ADDR_HORIZONTAL_LENGTH  12'h124
`define ADDR_LINE_PIXEL_COUNT   12'h125
`define ADDR_WINDOW_STATUS      12'h12f

// ==========================================================
// Field widths
`define LINE_FIELD_W            9
`define PIXEL_FIELD_W           11
`define REG_W                   12

// ==========================================================
// Reset values
`define RST_INPUT_LINE_COUNT    9'h000
`define RST_OUTPUT_LINE_COUNT   9'h000
`define RST_HORIZONTAL_START    11'h000
`define RST_HORIZONTAL_LENGTH   11'h2c0
`define RST_LINE_PIXEL_COUNT    11'h2c0

`endif

// file: hdl/two_entry_buffer.v
/*
 Holds a two-entry buffer with valid and ready on both sides.
 Assumes one clock and a synchronised active-low reset.
*/
`timescale 1ns/1ps

module two_entry_buffer #(
	parameter WIDTH = 17
) (
	input  wire             ref_clk,
	input  wire             rstSync_n,
	input  wire             inValid,
	output reg              inReady,
	input  wire [WIDTH-1:0] inData,
	output reg              outValid,
	input  wire             outReady,
	output reg  [WIDTH-1:0] outData
);

	reg  [WIDTH-1:0] slot1;
	reg  [1:0]       count;
	wire             push;
	wire             pop;

	assign push = inValid & inReady;
	assign pop  = outValid & outReady;

	// ==========================================================
	// Storage: outData is the head, slot1 the second entry
	always @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			count    <= 2'h0;
			inReady  <= 1'b0;
			outValid <= 1'b0;
			outData  <= {WIDTH{1'b0}};
			slot1    <= {WIDTH{1'b0}};
		end else begin
			case ({push, pop})
			2'b10: begin
				if (count == 2'h0)
					outData <= inData;
				else
					slot1 <= inData;
				count    <= count + 2'h1;
				outValid <= 1'b1;
				inReady  <= (count == 2'h0);
			end
			2'b01: begin
				// An emptied head is cleared so no stale line marker lingers
				outData  <= (count == 2'h2) ? slot1 : {WIDTH{1'b0}};
				count    <= count - 2'h1;
				outValid <= (count == 2'h2);
				inReady  <= 1'b1;
			end
			2'b11: begin
				if (count == 2'h1)
					outData <= inData;
				else begin
					outData <= slot1;
					slot1   <= inData;
				end
				inReady <= 1'b1;
			end
			default: begin
				inReady <= (count != 2'h2); // Full stalls the source
			end
			endcase
		end
	end

endmodule

// file: hdl/video_window_geometry.v
/*
 Holds the first output window's geometry registers and the line and pixel selection
 they steer on the scaled pixel stream.
 Assumes pixel inputs synchronous to ref_clk and a register port with one-cycle strobes.
 Assumes the source marks each line's first pixel and each field's first line.
 Limitations: line and pixel counters stop at their top value, so an overlong
 line or field is cropped rather than wrapped; dropped pixels still need room
 in the output buffer before they are accepted.
*/
// Added by the designer: the address-and-strobe port.
// Contract
// - Fewer output than input lines compresses the window by dropping whole lines.
// - Horizontal start names the first output pixel within the scaled full line.
// - A nonzero horizontal start crops the leading scaled pixels on the left.
// - Each window line carries horizontal length scaled pixels, fewer where the window runs past the line pixel count.
// - The input line count is the span of active lines per field from its first line.
`timescale 1ns/1ps
`include "video_window_defines.vh"

module video_window_geometry #(
	parameter DATA_W = 16
) (
	input  wire              ref_clk,
	input  wire              rst_n,
	input  wire [11:0]       regAddr,
	input  wire [11:0]       regWriteData,
	input  wire              regWrite,
	input  wire              regRead,
	output reg  [11:0]       regReadData,
	input  wire              pixValid,
	output wire              pixReady,
	input  wire [DATA_W-1:0] pixData,
	input  wire              pixLineStart,
	input  wire              pixFieldStart,
	output wire              outValid,
	input  wire              outReady,
	output wire [DATA_W-1:0] outData,
	output wire              outLineStart
);

	// Reset release
	reg  [1:0]                   rstPipe;
	wire                         rstSync_n;
	// Stored geometry fields
	reg  [`LINE_FIELD_W-1:0]     inputLineCount;
	reg  [`LINE_FIELD_W-1:0]     outputLineCount;
	reg  [`PIXEL_FIELD_W-1:0]    horizontalStart;
	reg  [`PIXEL_FIELD_W-1:0]    horizontalLength;
	reg  [`PIXEL_FIELD_W-1:0]    linePixelCount;
	// Position within the field and the line
	reg  [`LINE_FIELD_W-1:0]     lineIndex;
	reg  [`LINE_FIELD_W:0]       dropAcc;
	reg                          lineKept;
	reg  [`PIXEL_FIELD_W-1:0]    pixelIndex;
	// Values for the pixel now offered
	reg  [`LINE_FIELD_W-1:0]     curLine;
	reg  [`LINE_FIELD_W:0]       accSum;
	reg  [`LINE_FIELD_W:0]       next_dropAcc;
	reg                          curKept;
	reg  [`PIXEL_FIELD_W-1:0]    curPixel;
	reg  [`PIXEL_FIELD_W:0]      windowEnd;
	reg                          keepPixel;
	// Output buffer hookup
	wire                         bufReady;
	wire                         take;
	wire [DATA_W:0]              bufOut;

	// Address match for both write and read decode
	function hit;
		input [11:0] addr;
		input [11:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// ==========================================================
	// Reset release through two flip-flops
	// The rest of the block leaves reset two edges after rst_n rises
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rstPipe <= 2'h0;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstSync_n = rstPipe[1];

	// ==========================================================
	// Register writes; upper bits are not stored
	// Writes to unmapped offsets or to the status word are ignored
	always @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			inputLineCount   <= `RST_INPUT_LINE_COUNT;
			outputLineCount  <= `RST_OUTPUT_LINE_COUNT;
			horizontalStart  <= `RST_HORIZONTAL_START;
			horizontalLength <= `RST_HORIZONTAL_LENGTH;
			linePixelCount   <= `RST_LINE_PIXEL_COUNT;
		end else if (regWrite) begin
			if (hit(regAddr, `ADDR_INPUT_LINE_COUNT))
				inputLineCount <= regWriteData[`LINE_FIELD_W-1:0];
			if (hit(regAddr, `ADDR_OUTPUT_LINE_COUNT))
				outputLineCount <= regWriteData[`LINE_FIELD_W-1:0];
			if (hit(regAddr, `ADDR_HORIZONTAL_START))
				horizontalStart <= regWriteData[`PIXEL_FIELD_W-1:0];
			if (hit(regAddr, `ADDR_HORIZONTAL_LENGTH))
				horizontalLength <= regWriteData[`PIXEL_FIELD_W-1:0];
			if (hit(regAddr, `ADDR_LINE_PIXEL_COUNT))
				linePixelCount <= regWriteData[`PIXEL_FIELD_W-1:0];
		end
	end

	// ==========================================================
	// Register reads, data valid the cycle after the strobe
	// Status word: bit 9 current line kept, bits 8:0 current line index
	always @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n)
			regReadData <= 12'h000;
		else if (regRead) begin
			if (hit(regAddr, `ADDR_INPUT_LINE_COUNT))
				regReadData <= {3'h0, inputLineCount};
			else if (hit(regAddr, `ADDR_OUTPUT_LINE_COUNT))
				regReadData <= {3'h0, outputLineCount};
			else if (hit(regAddr, `ADDR_HORIZONTAL_START))
				regReadData <= {1'b0, horizontalStart};
			else if (hit(regAddr, `ADDR_HORIZONTAL_LENGTH))
				regReadData <= {1'b0, horizontalLength};
			else if (hit(regAddr, `ADDR_LINE_PIXEL_COUNT))
				regReadData <= {1'b0, linePixelCount};
			else if (hit(regAddr, `ADDR_WINDOW_STATUS))
				regReadData <= {2'h0, lineKept, lineIndex};
			else
				regReadData <= 12'h000; // Unmapped reads as zero
		end else
			regReadData <= 12'h000;
	end

	// ==========================================================
	// Line and pixel selection for the current input pixel
	always @* begin
		curLine      = lineIndex;
		accSum       = dropAcc;
		next_dropAcc = dropAcc;
		curKept      = lineKept;
		// Counters hold at their top value rather than wrap
		curPixel     = (pixelIndex == 11'h7ff) ? pixelIndex : pixelIndex + 11'h001;
		if (pixLineStart) begin
			curPixel = 11'h000;
			if (pixFieldStart)
				curLine = 9'h000;
			else if (lineIndex == 9'h1ff)
				curLine = lineIndex;
			else
				curLine = lineIndex + 9'h001;
			accSum  = (pixFieldStart ? 10'h000 : dropAcc) + {1'b0, outputLineCount};
			// Each line within the span adds the output count to the accumulator; a line is kept
			// when the sum reaches the input count, which spreads the kept lines
			// evenly over the span
			// even line dropping
			if (curLine >= inputLineCount) begin
				curKept      = 1'b0;
				next_dropAcc = accSum - {1'b0, outputLineCount};
			end else if (outputLineCount >= inputLineCount) begin
				curKept      = 1'b1;
				next_dropAcc = 10'h000;
			end else if (accSum >= {1'b0, inputLineCount}) begin
				curKept      = 1'b1;
				next_dropAcc = accSum - {1'b0, inputLineCount};
			end else begin
				curKept      = 1'b0;
				next_dropAcc = accSum;
			end
		end
		// One bit wider so start plus length cannot wrap
		windowEnd = {1'b0, horizontalStart} + {1'b0, horizontalLength};
		// crop left, fixed length within the scaled line
		keepPixel = curKept && (curPixel >= horizontalStart)
			&& ({1'b0, curPixel} < windowEnd) && (curPixel < linePixelCount);
	end

	assign take     = pixValid & bufReady;
	assign pixReady = bufReady;

	// ==========================================================
	// Line and pixel counters advance on each accepted pixel
	always @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			lineIndex  <= 9'h000;
			dropAcc    <= 10'h000;
			lineKept   <= 1'b0;
			pixelIndex <= 11'h000;
		end else if (take) begin
			lineIndex  <= curLine;
			dropAcc    <= next_dropAcc;
			lineKept   <= curKept;
			pixelIndex <= curPixel;
		end
	end

	// ==========================================================
	// Kept pixels pass through the buffer with their line marker
	// A full buffer stalls dropped pixels too, so line and pixel counts stay
	// in step with what the source has handed over
	two_entry_buffer #(
		.WIDTH (DATA_W + 1)
	) u_buffer (
		.ref_clk   (ref_clk),
		.rstSync_n (rstSync_n),
		.inValid   (pixValid & keepPixel),
		.inReady   (bufReady),
		.inData    ({curPixel == horizontalStart, pixData}),
		.outValid  (outValid),
		.outReady  (outReady),
		.outData   (bufOut)
	);

	assign outData      = bufOut[DATA_W-1:0];
	assign outLineStart = bufOut[DATA_W];

endmodule

// file: verification/video_window_geometry_asserts.sv
/*
 Port checker for the window geometry bank.
 Assumes binding to video_window_geometry and its defines header.
*/
`timescale 1ns/1ps
`include "video_window_defines.vh"

module video_window_geometry_asserts #(
	parameter DATA_W = 16
) (
	input logic              ref_clk,
	input logic              rst_n,
	input logic [11:0]       regAddr,
	input logic [11:0]       regWriteData,
	input logic              regWrite,
	input logic              regRead,
	input logic [11:0]       regReadData,
	input logic              pixValid,
	input logic              pixReady,
	input logic [DATA_W-1:0] pixData,
	input logic              pixLineStart,
	input logic              pixFieldStart,
	input logic              outValid,
	input logic              outReady,
	input logic [DATA_W-1:0] outData,
	input logic              outLineStart
);
	// ==========================================================
	// Register port and stream checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_read_quiet: assert property (!regRead |=> regReadData == 12'h000)
		else $error("read data outside read cycle");
	a_unmapped_zero: assert property (regRead && regAddr != `ADDR_WINDOW_STATUS
		&& (regAddr < `ADDR_INPUT_LINE_COUNT || regAddr > `ADDR_LINE_PIXEL_COUNT)
		|=> regReadData == 12'h000) else $error("unmapped read not zero");
	a_line_reserved: assert property (regRead && (regAddr == `ADDR_INPUT_LINE_COUNT
		|| regAddr == `ADDR_OUTPUT_LINE_COUNT) |=> regReadData[11:9] == 3'h0)
		else $error("line count upper bits set");
	a_pix_reserved: assert property (regRead && regAddr >= `ADDR_HORIZONTAL_START
		&& regAddr <= `ADDR_LINE_PIXEL_COUNT |=> !regReadData[11])
		else $error("pixel field upper bit set");
	// The bench's write leaves one idle edge before the read that follows
	a_start_readback: assert property (regWrite && regAddr == `ADDR_HORIZONTAL_START
		##2 regRead && regAddr == `ADDR_HORIZONTAL_START
		|=> regReadData == ($past(regWriteData, 3) & 12'h7ff)) else $error("start readback");
	a_out_hold: assert property (outValid && !outReady
		|=> outValid && $stable(outData) && $stable(outLineStart)) else $error("output dropped");
	a_start_valid: assert property (outLineStart |-> outValid)
		else $error("line start without valid");
	a_drain_bound: assert property ((!pixValid && outReady) [*5] |=> !outValid)
		else $error("phantom output word");
	c_first: cover property (outValid && outReady && outLineStart);
	c_refuse: cover property (pixValid && !pixReady);
	c_stall: cover property (outValid && !outReady);
endmodule

// file: verification/output_sink.sv
/*
 Downstream capture model: drives outReady with random and burst stalls.
 Assumes the same clock as the window block.
*/
`timescale 1ns/1ps

module output_sink (
	input  logic ref_clk,
	input  logic slow,
	input  logic outValid,
	output logic outReady
);
	logic [5:0] phase = 6'h00;

	// ==========================================================
	// Ready pattern, long stalls when slow to fill the buffer
	// The phase only advances while a word is offered
	always @(posedge ref_clk) begin
		phase <= phase + {5'h00, outValid};
		if (slow)
			outReady <= (phase > 6'h0f) && ($urandom % 4 != 0);
		else
			outReady <= ($urandom % 8 != 0);
	end
endmodule

// file: verification/test_video_window_geometry.sv
/*
 Self-checking bench for the window geometry bank.
 Assumes the design, defines header, sink model and checker compiled first.
*/
`timescale 1ns/1ps

module test_video_window_geometry;
	logic ref_clk, rst_n, regWrite, regRead, pixValid, pixLineStart, pixFieldStart, slow;
	logic        outValid, outReady, outLineStart, pixReady;
	logic [11:0] regAddr, regWriteData, regReadData, nIn, nOut, nPix, hs, hl;
	logic [15:0] pixData, outData;
	logic [16:0] expQ[$];
	logic [11:0] rv[5] = '{12'h000, 12'h000, 12'h000, 12'h2c0, 12'h2c0};
	int nFail = 0, checkCount = 0, nRefused = 0;

	video_window_geometry #(.DATA_W(16)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
		.regRead(regRead), .regReadData(regReadData), .pixValid(pixValid),
		.pixReady(pixReady), .pixData(pixData), .pixLineStart(pixLineStart),
		.pixFieldStart(pixFieldStart), .outValid(outValid), .outReady(outReady),
		.outData(outData), .outLineStart(outLineStart));
	output_sink sink (.ref_clk(ref_clk), .slow(slow), .outValid(outValid), .outReady(outReady));

	// ==========================================================
	// Clock, compare, closing report
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task chk(input string what, input logic [16:0] e, input logic [16:0] g);
		checkCount++;
		if (g !== e) begin
			nFail++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task endSim;
		$display("checks %0d failures %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// Register and pixel drivers
	task wr(input logic [11:0] a, input logic [11:0] d);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		// One idle edge keeps a strobe from being driven twice in one step
		@(posedge ref_clk);
	endtask
	task rd(input logic [11:0] a, input logic [11:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		@(posedge ref_clk);
		chk("read", {5'h00, e}, {5'h00, regReadData});
	endtask
	task px(input logic [15:0] d, input logic ls, input logic fs);
		int n;
		pixValid <= 1'b1;
		pixData <= d;
		pixLineStart <= ls;
		pixFieldStart <= fs;
		for (n = 0; n < 500; n++) begin
			@(posedge ref_clk);
			if (pixReady === 1'b1)
				break;
		end
		if (n == 500) begin
			chk("pixel accepted", 17'h0_0001, 17'h0_0000);
			endSim();
		end
	endtask
	function automatic logic lineKept(ref int acc, input int i, input int o);
		acc += o;
		lineKept = (acc >= i);
		if (lineKept)
			acc -= i;
	endfunction

	// ==========================================================
	// Output monitor against expected queue
	always @(posedge ref_clk) begin
		if (pixValid === 1'b1 && pixReady === 1'b0)
			nRefused++;
		if (outValid === 1'b1 && outReady === 1'b1)
			chk("pixel", (expQ.size() > 0) ? expQ.pop_front() : 17'h1_ffff,
				{outLineStart, outData});
	end

	// ==========================================================
	// Main sequence
	initial begin
		int acc, f, n, i;
		logic k;
		{rst_n, regWrite, regRead, pixValid, pixLineStart, pixFieldStart, slow} = 7'h00;
		{regAddr, regWriteData, pixData} = 40'h00_0000_0000;
		void'($urandom(32'h3286c4a8));
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		for (i = 0; i < 5; i++)
			rd(12'h121 + i[11:0], rv[i]);
		rd(12'h1ff, 12'h000);
		wr(12'h123, 12'h7ff);
		rd(12'h123, 12'h7ff);
		for (f = 0; f < 6; f++) begin
			slow <= f[0];
			nIn = 12'(1 + $urandom % 6);
			nPix = 12'(32 + 2 * ($urandom % 16));
			nOut = (f == 0) ? nIn : (f == 1) ? 12'h000 : 12'($urandom % (nIn + 1));
			hs = (f == 0) ? 12'h000 : 12'($urandom % (nPix / 2));
			hl = (f == 0) ? nPix : 12'(1 + $urandom % (nPix - hs));
			wr(12'h121, nIn);
			wr(12'h122, nOut);
			wr(12'h125, nPix);
			wr(12'h124, hl);
			wr(12'h123, hs);
			rd(12'h123, hs);
			acc = 0;
			for (n = 0; n < nIn; n++) begin
				k = lineKept(acc, nIn, nOut);
				for (i = 0; i < nPix; i++) begin
					if (k && i >= hs && i < hs + hl)
						expQ.push_back({i == hs, n[4:0], i[10:0]});
					px({n[4:0], i[10:0]}, i == 0, i == 0 && n == 0);
				end
			end
			pixValid <= 1'b0;
			for (i = 0; i < 2000 && expQ.size() > 0; i++)
				@(posedge ref_clk);
			chk("drained", 17'h0_0000, 17'(expQ.size()));
			if (expQ.size() > 0)
				endSim();
			// Status shows the last line's index and its keep decision
			rd(12'h12f, {2'h0, k, nIn[8:0] - 9'h001});
		end
		chk("refused", 17'h0_0001, {16'h0000, nRefused > 0});
		endSim();
	end
endmodule

bind video_window_geometry video_window_geometry_asserts #(.DATA_W(DATA_W)) chk_i (
	.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWriteData(regWriteData),
	.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
	.pixValid(pixValid), .pixReady(pixReady), .pixData(pixData),
	.pixLineStart(pixLineStart), .pixFieldStart(pixFieldStart), .outValid(outValid),
	.outReady(outReady), .outData(outData), .outLineStart(outLineStart));
